// file: hw/aot_regs.v
// Chosen here: register access over APB.
`timescale 1ns/1ps
`include "aot_defines.vh"

// ==========================================
// offset trim register bank, apb slave
module aot_regs
(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`AOT_ADDR_W-1:0] paddr,
	input wire [`AOT_PDATA_W-1:0] pwdata,
	input wire [`AOT_STRB_W-1:0] pstrb,
	output reg [`AOT_PDATA_W-1:0] prdata,
	output wire pready,
	output wire pslverr,
	output wire fuse_rd,
	output wire [`AOT_SEL_W-1:0] fuse_addr,
	input wire [`AOT_DATA_W-1:0] fuse_data,
	input wire [`AOT_TRIM_W-1:0] core2_first_input_offset,
	input wire core2_sample_second,
	input wire core3_sample_fourth,
	output reg [`AOT_TRIM_W-1:0] core2_applied_offset,
	output reg [`AOT_TRIM_W-1:0] core3_applied_offset,
	output reg [`AOT_TRIM_W-1:0] core4_applied_offset,
	output reg [`AOT_TRIM_W-1:0] core5_applied_offset,
	output wire trim_load_done
);

	// ==========================================
	// decode helpers

	// index of register number n
	function [`AOT_IDX_W-1:0] aot_index_of;
		input [`AOT_SEL_W-1:0] n;
		begin
			case (n)
				`AOT_N_CORE2_SECOND: aot_index_of = `AOT_IDX_CORE2_SECOND;
				`AOT_N_CORE3_THIRD: aot_index_of = `AOT_IDX_CORE3_THIRD;
				`AOT_N_CORE3_FOURTH: aot_index_of = `AOT_IDX_CORE3_FOURTH;
				`AOT_N_CORE4: aot_index_of = `AOT_IDX_CORE4;
				default: aot_index_of = `AOT_IDX_CORE5;
			endcase
		end
	endfunction

	// true when a byte address selects register number n
	function aot_hit;
		input [`AOT_ADDR_W-1:0] addr;
		input [`AOT_SEL_W-1:0] n;
		begin
			aot_hit = (addr == {aot_index_of(n), `AOT_BYTE_OFS});
		end
	endfunction

	// ==========================================
	// fuse loading

	wire load_we;
	wire [`AOT_SEL_W-1:0] load_sel;
	wire [`AOT_DATA_W-1:0] load_data;
	wire load_busy;
	reg load_busy_d_reg;
	reg load_busy_d2_reg;

	// factory trims are copied in before the bus is served
	aot_fuse_loader u_loader
	(
		.pclk(pclk),
		.presetn(presetn),
		.fuse_rd(fuse_rd),
		.fuse_addr(fuse_addr),
		.fuse_data(fuse_data),
		.load_we(load_we),
		.load_sel(load_sel),
		.load_data(load_data),
		.load_busy(load_busy)
	);

	// two extra cycles: the last trim lands, then a waiting read recaptures it
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			load_busy_d_reg <= 1'b1;
			load_busy_d2_reg <= 1'b1;
		end
		else
		begin
			load_busy_d_reg <= load_busy;
			load_busy_d2_reg <= load_busy_d_reg;
		end
	end

	assign trim_load_done = ~load_busy & ~load_busy_d_reg & ~load_busy_d2_reg;

	// ==========================================
	// apb handshake

	reg err_reg;
	wire setup_phase;
	wire access_done;
	wire bus_write;
	wire [`AOT_NREG-1:0] hit_vec;
	wire [`AOT_DATA_W-1:0] val_flat [0:`AOT_NREG-1];

	// bus is held off while fuses are loading
	assign pready = penable & trim_load_done;
	assign setup_phase = psel & ~(penable & pready);
	assign access_done = psel & penable & pready;
	assign bus_write = access_done & pwrite;
	assign pslverr = access_done & err_reg;

	// ==========================================
	// register storage, one word per trim
	genvar gi;
	generate
		for (gi = 0; gi < `AOT_NREG; gi = gi + 1)
		begin : g_trim
			reg [`AOT_DATA_W-1:0] val_reg;
			wire bus_we;
			wire fuse_we;

			assign hit_vec[gi] = aot_hit(paddr, gi[`AOT_SEL_W-1:0]);
			assign bus_we = bus_write & hit_vec[gi];
			assign fuse_we = load_we & (load_sel == gi[`AOT_SEL_W-1:0]);
			assign val_flat[gi] = val_reg;

			// fuse value first, later bus writes overwrite it
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					val_reg <= `AOT_RESET_VAL;
				else if (fuse_we)
					val_reg <= load_data;
				else if (bus_we)
				begin
					// reserved bits stored as written
					if (pstrb[0])
						val_reg[7:0] <= pwdata[7:0];
					if (pstrb[1])
						val_reg[15:8] <= pwdata[15:8];
				end
			end
		end
	endgenerate

	// ==========================================
	// read data and error, captured before the access edge
	reg [`AOT_DATA_W-1:0] rd_mux;
	integer ri;

	// select the addressed word, zero if none
	always @*
	begin
		rd_mux = `AOT_RESET_VAL;
		for (ri = 0; ri < `AOT_NREG; ri = ri + 1)
		begin
			if (hit_vec[ri])
				rd_mux = val_flat[ri];
		end
	end

	// prdata follows the addressed register until the access completes
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= `AOT_PRDATA_RESET;
			err_reg <= 1'b0;
		end
		else if (setup_phase)
		begin
			prdata <= {`AOT_UPPER_ZERO, rd_mux};
			err_reg <= ~(|hit_vec);
		end
	end

	// ==========================================
	// applied offsets to the converter cores

	// input selects come from same-clock steering logic
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			core2_applied_offset <= `AOT_TRIM_RESET;
			core3_applied_offset <= `AOT_TRIM_RESET;
			core4_applied_offset <= `AOT_TRIM_RESET;
			core5_applied_offset <= `AOT_TRIM_RESET;
		end
		else
		begin
			// core 2 picks its second-input trim when on that pair
			if (core2_sample_second)
				core2_applied_offset <= val_flat[`AOT_N_CORE2_SECOND][`AOT_TRIM_W-1:0];
			else
				core2_applied_offset <= core2_first_input_offset;
			// core 3 picks third or fourth input trim
			if (core3_sample_fourth)
				core3_applied_offset <= val_flat[`AOT_N_CORE3_FOURTH][`AOT_TRIM_W-1:0];
			else
				core3_applied_offset <= val_flat[`AOT_N_CORE3_THIRD][`AOT_TRIM_W-1:0];
			// core 4 trim regardless of input
			core4_applied_offset <= val_flat[`AOT_N_CORE4][`AOT_TRIM_W-1:0];
			// core 5 trim, unsigned as stored
			core5_applied_offset <= val_flat[`AOT_N_CORE5][`AOT_TRIM_W-1:0];
		end
	end

endmodule

// file: hw/aot_defines.vh
`ifndef AOT_DEFINES_VH
`define AOT_DEFINES_VH

// ==========================================
// widths
`define AOT_ADDR_W 12
`define AOT_IDX_W 10
`define AOT_PDATA_W 32
`define AOT_DATA_W 16
`define AOT_TRIM_W 12
`define AOT_NREG 5
`define AOT_SEL_W 3
`define AOT_STRB_W 4

// ==========================================
// register indices, byte address is four times the index
`define AOT_IDX_CORE2_SECOND 10'h336
`define AOT_IDX_CORE3_THIRD 10'h338
`define AOT_IDX_CORE3_FOURTH 10'h33a
`define AOT_IDX_CORE4 10'h33c
`define AOT_IDX_CORE5 10'h33e

// ==========================================
// register numbers inside the bank and in fuse memory
`define AOT_N_CORE2_SECOND 3'h0
`define AOT_N_CORE3_THIRD 3'h1
`define AOT_N_CORE3_FOURTH 3'h2
`define AOT_N_CORE4 3'h3
`define AOT_N_CORE5 3'h4
`define AOT_N_LAST 3'h4

// ==========================================
// reset values
`define AOT_RESET_VAL 16'h0000
`define AOT_TRIM_RESET 12'h000
`define AOT_PRDATA_RESET 32'h00000000
`define AOT_UPPER_ZERO 16'h0000
`define AOT_BYTE_OFS 2'h0

// ==========================================
// fuse loader states
`define AOT_ST_REQ 2'h0
`define AOT_ST_WAIT 2'h1
`define AOT_ST_DONE 2'h2

`endif

// file: hw/aot_fuse_loader.v
`timescale 1ns/1ps
`include "aot_defines.vh"

// ==========================================
// fuse loader: copies factory trims into the bank after reset
module aot_fuse_loader
(
	input wire pclk,
	input wire presetn,
	output reg fuse_rd,
	output reg [`AOT_SEL_W-1:0] fuse_addr,
	input wire [`AOT_DATA_W-1:0] fuse_data,
	output reg load_we,
	output reg [`AOT_SEL_W-1:0] load_sel,
	output reg [`AOT_DATA_W-1:0] load_data,
	output wire load_busy
);

	// loader states
	localparam [1:0] ST_REQ = `AOT_ST_REQ;
	localparam [1:0] ST_WAIT = `AOT_ST_WAIT;
	localparam [1:0] ST_DONE = `AOT_ST_DONE;

	reg [1:0] state_reg;
	reg [`AOT_SEL_W-1:0] cnt_reg;

	assign load_busy = (state_reg != ST_DONE);

	// walk the fuse words one by one, rom answers one cycle after the read
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= ST_REQ;
			cnt_reg <= `AOT_N_CORE2_SECOND;
			fuse_rd <= 1'b0;
			fuse_addr <= `AOT_N_CORE2_SECOND;
			load_we <= 1'b0;
			load_sel <= `AOT_N_CORE2_SECOND;
			load_data <= `AOT_RESET_VAL;
		end
		else
		begin
			fuse_rd <= 1'b0;
			load_we <= 1'b0;
			case (state_reg)
				ST_REQ:
				begin
					fuse_rd <= 1'b1;
					fuse_addr <= cnt_reg;
					state_reg <= ST_WAIT;
				end
				ST_WAIT:
				begin
					if (!fuse_rd)
					begin
						load_we <= 1'b1;
						load_sel <= cnt_reg;
						load_data <= fuse_data;
						if (cnt_reg == `AOT_N_LAST)
							state_reg <= ST_DONE;
						else
						begin
							cnt_reg <= cnt_reg + 3'h1;
							state_reg <= ST_REQ;
						end
					end
				end
				ST_DONE:
					state_reg <= ST_DONE;
				default:
					state_reg <= ST_DONE;
			endcase
		end
	end

endmodule

// file: tb/aot_regs_sva.sv
`timescale 1ns/1ps
// ====
// trim bank port checker
module aot_regs_sva
(
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic pready,
	input logic pslverr,
	input logic fuse_rd,
	input logic [11:0] core2_first_input_offset,
	input logic core2_sample_second,
	input logic [11:0] core2_applied_offset,
	input logic [11:0] core4_applied_offset,
	input logic trim_load_done
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// completing access and decode
	wire acc = psel && penable && pready;
	wire hit = paddr == 12'hcd8 || paddr == 12'hce0 || paddr == 12'hce8 ||
		paddr == 12'hcf0 || paddr == 12'hcf8;
	sequence wr_core4;
		acc && pwrite && paddr == 12'hcf0;
	endsequence
	ready_gate_a: assert property (pready == (penable && trim_load_done))
		else $error("pready not gated by load");
	map_err_a: assert property (pslverr == (acc && !hit))
		else $error("pslverr wrong");
	upper_zero_a: assert property (prdata[31:16] == 16'h0000)
		else $error("prdata upper half set");
	fuse_gap_a: assert property (fuse_rd |=> !fuse_rd [*2])
		else $error("fuse reads too close");
	load_end_a: assert property (!trim_load_done |-> ##[1:20] trim_load_done)
		else $error("fuse load too slow");
	done_hold_a: assert property (trim_load_done |=> trim_load_done)
		else $error("load done dropped");
	core4_write_a: assert property (wr_core4 |=> ##1 core4_applied_offset ==
		$past(pwdata[11:0], 2))
		else $error("core4 offset not applied");
	core2_first_a: assert property (trim_load_done && !core2_sample_second |=>
		core2_applied_offset == $past(core2_first_input_offset))
		else $error("core2 first input offset wrong");
endmodule

// file: tb/aot_regs_test.sv
`timescale 1ns/1ps
// ====
// trim bank testbench
module aot_regs_test;
	logic pclk, presetn, psel, penable, pwrite, c2s, c3f, e;
	logic [11:0] paddr, c2f;
	logic [31:0] pwdata, rd;
	logic [15:0] fuse_data;
	logic [11:0] adr [5];
	wire [31:0] prdata;
	wire pready, pslverr, fuse_rd, done;
	wire [2:0] fuse_addr;
	wire [11:0] o2, o3, o4, o5;
	int bad_count, n_tests;
	aot_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .fuse_rd(fuse_rd), .fuse_addr(fuse_addr),
		.fuse_data(fuse_data), .core2_first_input_offset(c2f), .core2_sample_second(c2s),
		.core3_sample_fourth(c3f), .core2_applied_offset(o2), .core3_applied_offset(o3),
		.core4_applied_offset(o4), .core5_applied_offset(o5), .trim_load_done(done));
	// clock
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// fuse rom, valid one cycle after a read
	always @(posedge pclk)
		fuse_data <= fuse_rd ? 16'h0a50 + {13'h0000, fuse_addr} : ~fuse_data;
	task test_done;
		begin
			$display("comparisons %0d mismatches %0d", n_tests, bad_count);
			if (bad_count == 0 && n_tests > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	task chk(input string nm, input [31:0] ex, input [31:0] got);
		begin
			n_tests++;
			if (got !== ex)
			begin
				bad_count++;
				$display("MISMATCH %s exp %h got %h", nm, ex, got);
			end
		end
	endtask
	// one apb transfer, waits for pready
	task apb(input [11:0] a, input w, input [31:0] d);
		int i;
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			i = 0;
			@(posedge pclk);
			while (pready !== 1'b1 && i < 100)
			begin
				i++;
				@(posedge pclk);
			end
			if (pready !== 1'b1)
			begin
				bad_count++;
				test_done;
			end
			rd = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task rdc(input [11:0] a, input [15:0] ex);
		begin
			apb(a, 1'b0, 32'h0);
			chk("prdata", {16'h0000, ex}, rd);
			chk("pslverr", 32'h0, {31'h0, e});
		end
	endtask
	task outs(input [11:0] x2, input [11:0] x3);
		begin
			repeat (2) @(posedge pclk);
			chk("core2", {20'h0, x2}, {20'h0, o2});
			chk("core3", {20'h0, x3}, {20'h0, o3});
			chk("core4", 32'hffc, {20'h0, o4});
			chk("core5", 32'hffb, {20'h0, o5});
		end
	endtask
	initial
	begin
		presetn = 1'b0;
		{psel, penable, pwrite, c2s, c3f} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		fuse_data = 16'h0000;
		c2f = 12'h5a5;
		bad_count = 0;
		n_tests = 0;
		adr = '{12'hcd8, 12'hce0, 12'hce8, 12'hcf0, 12'hcf8};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int n = 0; n < 5; n++)
			rdc(adr[4 - n], 16'h0a54 - n);
		$display("fuse load test done");
		for (int n = 0; n < 5; n++)
		begin
			apb(adr[n], 1'b1, 32'h0fff - n);
			rdc(adr[n], 16'h0fff - n);
		end
		$display("readback test done");
		c2s <= 1'b1;
		c3f <= 1'b1;
		outs(12'hfff, 12'hffd);
		c2s <= 1'b0;
		c3f <= 1'b0;
		outs(12'h5a5, 12'hffe);
		$display("applied offset test done");
		for (int n = 0; n < 2; n++)
		begin
			apb(n ? 12'hcdc : 12'hcd0, 1'b1, 32'h0123);
			chk("wr err", 32'h1, {31'h0, e});
			apb(n ? 12'hcdc : 12'hcd0, 1'b0, 32'h0);
			chk("rd err", 32'h1, {31'h0, e});
			chk("rd zero", 32'h0, rd);
		end
		rdc(adr[0], 16'h0fff);
		$display("unmapped test done");
		test_done;
	end
endmodule
bind aot_regs aot_regs_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .fuse_rd(fuse_rd),
	.core2_first_input_offset(core2_first_input_offset),
	.core2_sample_second(core2_sample_second), .core2_applied_offset(core2_applied_offset),
	.core4_applied_offset(core4_applied_offset), .trim_load_done(trim_load_done));
